// ===== include/pkt_cfg.svh
// packet framer constants: framing, timing, codes and the rule summary
// assumes a 200 MHz core clock and a serial host link into the framer's own uart
// Operation
// - default link speed is 19200 baud, 8 data bits, no parity, 1 stop
// - host command may switch the link speed to 115200 baud
// - packet is type byte, length byte, payload, then checksum
// - top two type bits give class; low six bits give code
// - valid structure but illegal content draws a class 11 answer
// - length byte counts payload bytes and stays within 0 to 18
// - checksum is a 16-bit crc over all bytes except itself
// - checksum goes low byte first, right after the last payload byte
// - every received packet is acknowledged within 250 ms; code answers only good-checksum commands taken while none is pending
// - reports go out on their own, interleaved with acknowledges
// - key report type 0x80, one byte: press 1..6, release 7..12
// - only key events enabled by the host are reported
// - temperature report 0x82: index, count low, count high, crc status
// - each selected sensor, up to 32, reports once per second
// - each command gets one answer whose low six type bits match; code drops unanswered a command arriving while one is pending
// - sensor bus bridge moves at most 15 bytes out, 14 bytes in
// - at most 32 devices on the sensor bus in total
// - readings convert to celsius or fahrenheit for the live display
// - normal answer type is 0x40 or code; echo returns the payload
`ifndef PKT_CFG_SVH
`define PKT_CFG_SVH
`define CLK_HZ 200000000
`define BAUD_SLOW 19200
`define BAUD_FAST 115200
`define BAUD_DIV_SLOW (`CLK_HZ / `BAUD_SLOW)
`define BAUD_DIV_FAST (`CLK_HZ / `BAUD_FAST)
`define ACK_TIME_MS 250
`define ACK_CYCLES ((`CLK_HZ / 1000) * `ACK_TIME_MS)
`define REPORT_CYCLES `CLK_HZ
`define MAX_LEN 8'h12
`define CLS_CMD 2'h0
`define CLS_RSP 2'h1
`define CLS_ERR 2'h3
`define TYPE_KEY 8'h80
`define TYPE_TEMP 8'h82
`define TEMP_LEN 8'h04
`define KEY_LEN 8'h01
`define KEY_RELEASE_BASE 8'h07
`define CODE_PING 6'h00
`define CODE_BAUD 6'h21
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'h8408
`define OW_MAX_TX 15
`define OW_MAX_RX 14
`define OW_MAX_DEV 32
`endif

// ===== include/pkt_pkg.sv
// packet framer types
// assumes pkt_cfg.svh holds the numeric constants
package pkt_pkg;
  typedef enum logic [2:0] {RX_TYPE, RX_LEN, RX_DATA, RX_CRCL, RX_CRCH} rx_state_t;
  typedef enum logic [2:0] {TX_IDLE, TX_TYPE, TX_LEN, TX_DATA, TX_CRCL, TX_CRCH} tx_state_t;
  typedef enum logic [1:0] {SRC_NONE, SRC_ACK, SRC_KEY, SRC_TEMP} tx_src_t;
endpackage

// ===== hw/pkt_framer.sv
// host link packet framer: uart, receive parser, answer and report sender
// assumes keys, sensor readings and command legality come from other logic
`timescale 1ns/1ps
`include "pkt_cfg.svh"
module pkt_framer #(
  parameter int ACK_CYC = `ACK_CYCLES,
  parameter int REPORT_CYC = `REPORT_CYCLES,
  parameter int DIV_SLOW = `BAUD_DIV_SLOW,
  parameter int DIV_FAST = `BAUD_DIV_FAST
) (
  input wire logic i_clk, // 200 MHz core clock
  input wire logic i_rst_b, // async reset, active low
  input wire logic i_rxd, // serial data from host
  input wire logic [5:0] i_key_press, // one-cycle press pulses, up..exit
  input wire logic [5:0] i_key_release, // one-cycle release pulses
  input wire logic [5:0] i_press_mask, // host key press enables
  input wire logic [5:0] i_release_mask, // host key release enables
  input wire logic [31:0] i_temp_sel, // sensors chosen for reporting
  input wire logic [15:0] i_temp_count, // count of sensor o_temp_idx
  input wire logic i_temp_crc_ok, // sensor bus crc good
  input wire logic i_cmd_illegal, // content check of held command
  output logic o_txd, // serial data to host
  output logic o_cmd_valid, // good command received, one-cycle pulse
  output logic [7:0] o_cmd_type, // type byte of received command
  output logic [7:0] o_cmd_len, // its payload length
  output logic [4:0] o_temp_idx, // sensor whose count is wanted
  output logic o_fast_baud // link runs at 115200
);
  logic [7:0] buf_ff [0:17]; // payload, also echoed back
  // uart state
  logic [15:0] rx_cnt_ff, nxt_rx_cnt; logic [3:0] rx_bit_ff, nxt_rx_bit;
  logic [7:0] rx_sh_ff, nxt_rx_sh; logic rx_busy_ff, nxt_rx_busy, rx_stb;
  logic rxd_m_ff, rxd_s_ff;
  logic [15:0] tx_cnt_ff, nxt_tx_cnt; logic [3:0] tx_bit_ff, nxt_tx_bit;
  logic [9:0] tx_sh_ff, nxt_tx_sh; logic txd_ff, nxt_txd;
  logic tx_load, tx_idle;
  logic [7:0] tx_byte;
  logic fast_ff, nxt_fast, want_fast_ff, nxt_want_fast;
  logic [15:0] div;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  assign div = fast_ff ? 16'(DIV_FAST) : 16'(DIV_SLOW);

  // two-flop input synchroniser
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rxd_m_ff <= 1'b1;
      rxd_s_ff <= 1'b1;
    end else begin
      rxd_m_ff <= i_rxd;
      rxd_s_ff <= rxd_m_ff;
    end
  end

  // receiver 8N1: start edge, sample mid bit
  always_comb begin
    nxt_rx_cnt = rx_cnt_ff;
    nxt_rx_bit = rx_bit_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_busy = rx_busy_ff;
    rx_stb = 1'b0;
    if (!rx_busy_ff) begin
      if (!rxd_s_ff) begin
        nxt_rx_busy = 1'b1;
        nxt_rx_cnt = div >> 1;
        nxt_rx_bit = 4'h0;
      end
    end else if (rx_cnt_ff != 16'h0000) begin
      nxt_rx_cnt = rx_cnt_ff - 16'h0001;
    end else begin
      nxt_rx_cnt = div - 16'h0001;
      nxt_rx_bit = rx_bit_ff + 4'h1;
      if (rx_bit_ff == 4'h0) begin
        nxt_rx_busy = !rxd_s_ff; // false start is dropped
      end else if (rx_bit_ff == 4'h9) begin
        nxt_rx_busy = 1'b0;
        rx_stb = rxd_s_ff; // framing error drops the byte
      end else begin
        nxt_rx_sh = {rxd_s_ff, rx_sh_ff[7:1]};
      end
    end
  end

  // transmitter shifts start, 8 data lsb first, stop
  always_comb begin
    nxt_tx_cnt = tx_cnt_ff;
    nxt_tx_bit = tx_bit_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_txd = txd_ff;
    if (tx_load) begin
      nxt_tx_sh = {1'b1, tx_byte, 1'b0};
      nxt_tx_bit = 4'hA;
      nxt_tx_cnt = 16'h0000;
    end else if (tx_cnt_ff != 16'h0000) begin
      // the count also runs out the stop bit, else the next start bit could cut it short
      nxt_tx_cnt = tx_cnt_ff - 16'h0001;
    end else if (tx_bit_ff != 4'h0) begin
      nxt_txd = tx_sh_ff[0];
      nxt_tx_sh = {1'b1, tx_sh_ff[9:1]};
      nxt_tx_bit = tx_bit_ff - 4'h1;
      nxt_tx_cnt = div - 16'h0001;
    end
  end
  assign tx_idle = (tx_bit_ff == 4'h0) && (tx_cnt_ff == 16'h0000);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_cnt_ff <= 16'h0000; rx_bit_ff <= 4'h0; rx_sh_ff <= 8'h00; rx_busy_ff <= 1'b0;
      tx_cnt_ff <= 16'h0000; tx_bit_ff <= 4'h0; tx_sh_ff <= 10'h3FF; txd_ff <= 1'b1;
    end else begin
      rx_cnt_ff <= nxt_rx_cnt; rx_bit_ff <= nxt_rx_bit;
      rx_sh_ff <= nxt_rx_sh; rx_busy_ff <= nxt_rx_busy;
      tx_cnt_ff <= nxt_tx_cnt; tx_bit_ff <= nxt_tx_bit;
      tx_sh_ff <= nxt_tx_sh; txd_ff <= nxt_txd;
    end
  end

  // packet parser state
  pkt_pkg::rx_state_t rst_ff, nxt_rst;
  logic [7:0] rtype_ff, nxt_rtype, rlen_ff, nxt_rlen, ridx_ff, nxt_ridx;
  logic [15:0] rcrc_ff, nxt_rcrc; logic [7:0] rcrcl_ff, nxt_rcrcl;
  logic got_ff, nxt_got; logic pend_ff, nxt_pend;
  logic ack_done;
  logic [31:0] ack_tmr_ff, nxt_ack_tmr;

  // type, length, payload, crc low then high; bad crc or length resyncs
  always_comb begin
    nxt_rst = rst_ff;
    nxt_rtype = rtype_ff;
    nxt_rlen = rlen_ff;
    nxt_ridx = ridx_ff;
    nxt_rcrc = rcrc_ff;
    nxt_rcrcl = rcrcl_ff;
    nxt_got = 1'b0;
    nxt_pend = pend_ff && !ack_done;
    if (rx_stb) begin
      unique case (rst_ff)
        pkt_pkg::RX_TYPE: begin
          nxt_rtype = rx_sh_ff;
          nxt_rcrc = crc_step(`CRC_INIT, rx_sh_ff);
          nxt_rst = pkt_pkg::RX_LEN;
        end
        pkt_pkg::RX_LEN: begin
          nxt_rlen = rx_sh_ff;
          nxt_ridx = 8'h00;
          nxt_rcrc = crc_step(rcrc_ff, rx_sh_ff);
          if (rx_sh_ff > `MAX_LEN) nxt_rst = pkt_pkg::RX_TYPE;
          else if (rx_sh_ff == 8'h00) nxt_rst = pkt_pkg::RX_CRCL;
          else nxt_rst = pkt_pkg::RX_DATA;
        end
        pkt_pkg::RX_DATA: begin
          nxt_ridx = ridx_ff + 8'h01;
          nxt_rcrc = crc_step(rcrc_ff, rx_sh_ff);
          if (ridx_ff + 8'h01 == rlen_ff) nxt_rst = pkt_pkg::RX_CRCL;
        end
        pkt_pkg::RX_CRCL: begin
          nxt_rcrcl = rx_sh_ff;
          nxt_rst = pkt_pkg::RX_CRCH;
        end
        pkt_pkg::RX_CRCH: begin
          nxt_rst = pkt_pkg::RX_TYPE;
          // only host commands are taken; a new one drops while one is pending
          if ({rx_sh_ff, rcrcl_ff} == ~rcrc_ff && rtype_ff[7:6] == `CLS_CMD && !pend_ff) begin
            nxt_got = 1'b1;
            nxt_pend = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_ff <= pkt_pkg::RX_TYPE; rtype_ff <= 8'h00; rlen_ff <= 8'h00;
      ridx_ff <= 8'h00; rcrc_ff <= `CRC_INIT; rcrcl_ff <= 8'h00;
      got_ff <= 1'b0; pend_ff <= 1'b0;
    end else begin
      rst_ff <= nxt_rst; rtype_ff <= nxt_rtype; rlen_ff <= nxt_rlen;
      ridx_ff <= nxt_ridx; rcrc_ff <= nxt_rcrc; rcrcl_ff <= nxt_rcrcl;
      got_ff <= nxt_got; pend_ff <= nxt_pend;
    end
  end

  // payload store
  always_ff @(posedge i_clk) begin
    if (rx_stb && rst_ff == pkt_pkg::RX_DATA && !pend_ff) buf_ff[ridx_ff[4:0]] <= rx_sh_ff;
  end

  // key and temperature report sources
  logic [11:0] kev_ff, nxt_kev; logic [3:0] kcode;
  logic [31:0] sec_ff, nxt_sec; logic [4:0] tidx_ff, nxt_tidx;
  logic tscan_ff, nxt_tscan; logic twant;

  always_comb begin
    kcode = 4'h0;
    for (int i = 11; i >= 0; i--) begin
      if (kev_ff[i]) kcode = 4'(i + 1);
    end
  end
  assign twant = tscan_ff && i_temp_sel[tidx_ff];

  // transmit scheduler: answers first, reports fill the gaps
  pkt_pkg::tx_state_t tst_ff, nxt_tst; pkt_pkg::tx_src_t src_ff, nxt_src;
  logic [7:0] ttype_ff, nxt_ttype, tlen_ff, nxt_tlen, tidxb_ff, nxt_tidxb;
  logic [15:0] tcrc_ff, nxt_tcrc; logic [7:0] tdat;
  logic [7:0] tpay [0:3]; logic [7:0] kbyte_ff, nxt_kbyte;
  logic [15:0] tcnt_ff, nxt_tcnt; logic tok_ff, nxt_tok; logic [4:0] tsen_ff, nxt_tsen;
  logic take_key, take_temp;

  always_comb begin
    tpay[0] = {3'b000, tsen_ff};
    tpay[1] = tcnt_ff[7:0];
    tpay[2] = tcnt_ff[15:8];
    tpay[3] = {7'h00, tok_ff};
    unique case (src_ff)
      pkt_pkg::SRC_KEY: tdat = kbyte_ff;
      pkt_pkg::SRC_TEMP: tdat = tpay[tidxb_ff[1:0]];
      default: tdat = buf_ff[tidxb_ff[4:0]];
    endcase
  end

  always_comb begin
    nxt_tst = tst_ff; nxt_src = src_ff; nxt_ttype = ttype_ff; nxt_tlen = tlen_ff;
    nxt_tidxb = tidxb_ff; nxt_tcrc = tcrc_ff; nxt_kbyte = kbyte_ff;
    nxt_tcnt = tcnt_ff; nxt_tok = tok_ff; nxt_fast = fast_ff;
    nxt_want_fast = want_fast_ff; nxt_tsen = tsen_ff;
    tx_load = 1'b0; tx_byte = 8'h00; ack_done = 1'b0; take_key = 1'b0; take_temp = 1'b0;
    unique case (tst_ff)
      pkt_pkg::TX_IDLE: begin
        if (pend_ff && !got_ff) begin
          nxt_src = pkt_pkg::SRC_ACK;
          nxt_ttype = {i_cmd_illegal ? `CLS_ERR : `CLS_RSP, rtype_ff[5:0]};
          nxt_tlen = (i_cmd_illegal || rtype_ff[5:0] != `CODE_PING) ? 8'h00 : rlen_ff;
          nxt_tst = pkt_pkg::TX_TYPE;
        end else if (kcode != 4'h0) begin
          take_key = 1'b1;
          nxt_src = pkt_pkg::SRC_KEY;
          nxt_ttype = `TYPE_KEY;
          nxt_tlen = `KEY_LEN;
          nxt_kbyte = {4'h0, kcode};
          nxt_tst = pkt_pkg::TX_TYPE;
        end else if (twant) begin
          take_temp = 1'b1;
          nxt_src = pkt_pkg::SRC_TEMP;
          nxt_ttype = `TYPE_TEMP;
          nxt_tlen = `TEMP_LEN;
          nxt_tcnt = i_temp_count;
          nxt_tok = i_temp_crc_ok;
          nxt_tsen = tidx_ff; // scan index moves on while the report is sent
          nxt_tst = pkt_pkg::TX_TYPE;
        end
      end
      pkt_pkg::TX_TYPE: if (tx_idle) begin
        tx_load = 1'b1; tx_byte = ttype_ff;
        nxt_tcrc = crc_step(`CRC_INIT, ttype_ff);
        nxt_tst = pkt_pkg::TX_LEN;
      end
      pkt_pkg::TX_LEN: if (tx_idle) begin
        tx_load = 1'b1; tx_byte = tlen_ff;
        nxt_tcrc = crc_step(tcrc_ff, tlen_ff);
        nxt_tidxb = 8'h00;
        nxt_tst = (tlen_ff == 8'h00) ? pkt_pkg::TX_CRCL : pkt_pkg::TX_DATA;
      end
      pkt_pkg::TX_DATA: if (tx_idle) begin
        tx_load = 1'b1; tx_byte = tdat;
        nxt_tcrc = crc_step(tcrc_ff, tdat);
        nxt_tidxb = tidxb_ff + 8'h01;
        if (tidxb_ff + 8'h01 == tlen_ff) nxt_tst = pkt_pkg::TX_CRCL;
      end
      pkt_pkg::TX_CRCL: if (tx_idle) begin
        tx_load = 1'b1; tx_byte = ~tcrc_ff[7:0];
        nxt_tst = pkt_pkg::TX_CRCH;
      end
      pkt_pkg::TX_CRCH: if (tx_idle) begin
        tx_load = 1'b1; tx_byte = ~tcrc_ff[15:8];
        nxt_tst = pkt_pkg::TX_IDLE;
        if (src_ff == pkt_pkg::SRC_ACK) begin
          ack_done = 1'b1;
          // new speed is held back until the stop bit of this answer has gone out
          if (ttype_ff[7:6] == `CLS_RSP && rtype_ff[5:0] == `CODE_BAUD && rlen_ff == 8'h01)
            nxt_want_fast = (buf_ff[0] != 8'h00);
        end
      end
    endcase
    // rate follows the request only on an idle output line, so no sent frame mixes bit times
    if (tx_idle && !tx_load) nxt_fast = want_fast_ff;
  end

  // key events latch if enabled; set beats the take of the same bit
  always_comb begin
    nxt_kev = kev_ff | {i_key_release & i_release_mask, i_key_press & i_press_mask};
    if (take_key) nxt_kev[kcode - 4'h1] = 1'b0;
    if (take_key) nxt_kev = nxt_kev | {i_key_release & i_release_mask, i_key_press & i_press_mask};
    nxt_sec = (sec_ff == 32'(REPORT_CYC - 1)) ? 32'h0 : sec_ff + 32'h1;
    nxt_tscan = tscan_ff || (sec_ff == 32'(REPORT_CYC - 1));
    nxt_tidx = tidx_ff;
    if (tscan_ff && (take_temp || !i_temp_sel[tidx_ff])) begin
      nxt_tidx = tidx_ff + 5'h01;
      if (tidx_ff == 5'h1F) nxt_tscan = 1'b0;
    end
    nxt_ack_tmr = pend_ff ? ack_tmr_ff + 32'h1 : 32'h0;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tst_ff <= pkt_pkg::TX_IDLE; src_ff <= pkt_pkg::SRC_NONE; ttype_ff <= 8'h00;
      tlen_ff <= 8'h00; tidxb_ff <= 8'h00; tcrc_ff <= `CRC_INIT; kbyte_ff <= 8'h00;
      tcnt_ff <= 16'h0000; tok_ff <= 1'b0; fast_ff <= 1'b0; kev_ff <= 12'h000;
      sec_ff <= 32'h0; tscan_ff <= 1'b0; tidx_ff <= 5'h00; ack_tmr_ff <= 32'h0;
      want_fast_ff <= 1'b0; tsen_ff <= 5'h00;
    end else begin
      want_fast_ff <= nxt_want_fast; tsen_ff <= nxt_tsen;
      tst_ff <= nxt_tst; src_ff <= nxt_src; ttype_ff <= nxt_ttype;
      tlen_ff <= nxt_tlen; tidxb_ff <= nxt_tidxb; tcrc_ff <= nxt_tcrc; kbyte_ff <= nxt_kbyte;
      tcnt_ff <= nxt_tcnt; tok_ff <= nxt_tok; fast_ff <= nxt_fast; kev_ff <= nxt_kev;
      sec_ff <= nxt_sec; tscan_ff <= nxt_tscan; tidx_ff <= nxt_tidx; ack_tmr_ff <= nxt_ack_tmr;
    end
  end

  assign o_txd = txd_ff;
  assign o_cmd_valid = got_ff;
  assign o_cmd_type = rtype_ff;
  assign o_cmd_len = rlen_ff;
  assign o_temp_idx = tidx_ff;
  assign o_fast_baud = fast_ff;
endmodule

// ===== verif/pkt_framer_props.sv
// port assertions for the host link packet framer
// assumes a bind onto pkt_framer; watches only its serial, command and rate flag ports
`timescale 1ns/1ps
`include "pkt_cfg.svh"
module pkt_framer_props #(
  parameter int DIV_S = `BAUD_DIV_SLOW,
  parameter int DIV_F = `BAUD_DIV_FAST
) (
  input wire logic i_clk, // core clock
  input wire logic i_rst_b, // async reset, active low
  input wire logic i_rxd, // host serial in
  input wire logic o_txd, // serial out
  input wire logic o_cmd_valid, // command taken pulse
  input wire logic [7:0] o_cmd_type, // command type byte
  input wire logic [7:0] o_cmd_len, // command length
  input wire logic o_fast_baud // fast rate flag
);
  int lo_cnt;
  int hi_cnt;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // run lengths of the output line; a low run must be whole bit times
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lo_cnt <= 0;
      hi_cnt <= 0;
    end else begin
      lo_cnt <= o_txd ? 0 : lo_cnt + 1;
      hi_cnt <= o_txd ? hi_cnt + 1 : 0;
    end
  end
  a_valid_one_shot: assert property (o_cmd_valid |=> (!o_cmd_valid) [*8])
    else $error("command pulse not single");
  a_taken_is_cmd: assert property (o_cmd_valid |-> o_cmd_type[7:6] == `CLS_CMD)
    else $error("non-command class taken");
  a_taken_len_max: assert property (o_cmd_valid |-> o_cmd_len <= `MAX_LEN)
    else $error("command length above limit taken");
  a_taken_at_stop: assert property (o_cmd_valid |-> i_rxd)
    else $error("command taken before last stop bit");
  a_answer_starts: assert property (o_cmd_valid && hi_cnt > 12 * DIV_S |-> ##4 !o_txd)
    else $error("answer not started on idle line");
  a_bit_whole: assert property (o_txd && lo_cnt != 0 |->
    lo_cnt % (o_fast_baud ? DIV_F : DIV_S) == 0)
    else $error("low run not whole bit times");
  a_switch_idle: assert property ($changed(o_fast_baud) |-> o_txd && hi_cnt > 0)
    else $error("rate changed inside a frame");
  a_rate_by_cmd: assert property ($rose(o_fast_baud) |->
    o_cmd_type == {`CLS_CMD, `CODE_BAUD})
    else $error("fast rate without rate command");
endmodule
bind pkt_framer pkt_framer_props #(.DIV_S(DIV_SLOW), .DIV_F(DIV_FAST)) pkt_framer_props_inst (
  .i_clk(i_clk),
  .i_rst_b(i_rst_b),
  .i_rxd(i_rxd),
  .o_txd(o_txd),
  .o_cmd_valid(o_cmd_valid),
  .o_cmd_type(o_cmd_type),
  .o_cmd_len(o_cmd_len),
  .o_fast_baud(o_fast_baud)
);

// ===== verif/host_model.sv
// host side model: 8N1 byte sender and a receive byte buffer
// assumes the framer's rate flag tells which bit time is in use
`timescale 1ns/1ps
`include "pkt_cfg.svh"
module host_model #(
  parameter int BIT_SLOW = `BAUD_DIV_SLOW,
  parameter int BIT_FAST = `BAUD_DIV_FAST
) (
  input wire logic i_clk, // core clock
  input wire logic i_fast, // framer at fast rate
  input wire logic i_txd, // framer serial out
  output logic o_rxd // serial line to framer
);
  logic [7:0] rxq[$];
  initial o_rxd = 1'b1;
  function automatic logic [15:0] crc_add(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? (c >> 1) ^ `CRC_POLY : c >> 1;
    end
    return c;
  endfunction
  function automatic int bit_t();
    return i_fast ? BIT_FAST : BIT_SLOW;
  endfunction
  // start bit, data lsb first, one stop bit
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    int n;
    f = {1'b1, b, 1'b0};
    n = bit_t();
    for (int i = 0; i < 10; i++) begin
      o_rxd = f[i];
      repeat (n) @(posedge i_clk);
      #1;
    end
  endtask
  // bad is xored into the checksum so a drop can be provoked
  task automatic send_pkt(input logic [7:0] t, input logic [7:0] n, input logic [7:0] d,
    input logic [7:0] bad);
    logic [15:0] c;
    c = crc_add(crc_add(16'hFFFF, t), n);
    if (n != 8'h00) c = crc_add(c, d);
    c = ~c ^ {8'h00, bad};
    send_byte(t);
    send_byte(n);
    if (n != 8'h00) send_byte(d);
    send_byte(c[7:0]);
    send_byte(c[15:8]);
  endtask
  // mid-bit sampling; bytes are buffered so reports never block answers
  initial forever begin
    logic [7:0] b;
    int n;
    @(negedge i_txd);
    n = bit_t();
    repeat (n / 2) @(posedge i_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (n) @(posedge i_clk);
      b[i] = i_txd;
    end
    repeat (n) @(posedge i_clk);
    rxq.push_back(b);
  end
endmodule

// ===== verif/pkt_framer_tb.sv
// bench for the host link packet framer: echo, rate switch, drops, errors,
// key and temperature reports; assumes host_model on the serial pins
`timescale 1ns/1ps
`include "pkt_cfg.svh"
module pkt_framer_tb;
  localparam int RPT = 5000;
  localparam int LIMIT = 90000;
  // shortened bit times keep the run short; the ratio of the two rates is kept
  localparam int DIV_S = 96;
  localparam int DIV_F = 16;
  logic clk, rst_b, rxd, txd, cmd_valid, fast, illegal;
  logic [5:0] press, rel, pmask, rmask, code;
  logic [31:0] sel, r;
  logic [7:0] ctype, clen;
  logic [4:0] idx, s;
  int error_cnt = 0;
  int check_count = 0;
  int seed, j, vcnt = 0, cyc = 0;
  // sensor counts follow the scan index so every report differs
  pkt_framer #(.REPORT_CYC(RPT), .DIV_SLOW(DIV_S), .DIV_FAST(DIV_F)) pkt_framer_inst (
    .i_clk(clk), .i_rst_b(rst_b), .i_rxd(rxd), .i_key_press(press), .i_key_release(rel),
    .i_press_mask(pmask), .i_release_mask(rmask), .i_temp_sel(sel),
    .i_temp_count({idx, 11'h2A5}), .i_temp_crc_ok(idx[0]), .i_cmd_illegal(illegal),
    .o_txd(txd), .o_cmd_valid(cmd_valid), .o_cmd_type(ctype), .o_cmd_len(clen),
    .o_temp_idx(idx), .o_fast_baud(fast)
  );
  host_model #(.BIT_SLOW(DIV_S), .BIT_FAST(DIV_F)) host_model_inst (
    .i_clk(clk), .i_fast(fast), .i_txd(txd), .o_rxd(rxd)
  );
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // command pulse counter and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cmd_valid === 1'b1) vcnt <= vcnt + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // returns just off an edge so callers may drive inputs at once
  task automatic get_byte(output logic [7:0] b);
    while (host_model_inst.rxq.size() == 0) @(posedge clk);
    #1;
    b = host_model_inst.rxq.pop_front();
  endtask
  task automatic expect_pkt(input logic [7:0] t, input logic [7:0] n, input logic [31:0] d);
    logic [7:0] b;
    logic [15:0] c;
    c = 16'hFFFF;
    get_byte(b);
    chk("type", t, b);
    c = host_model_inst.crc_add(c, b);
    get_byte(b);
    chk("length", n, b);
    c = host_model_inst.crc_add(c, b);
    for (int i = 0; i < n; i++) begin
      get_byte(b);
      chk("payload", d[8*i+:8], b);
      c = host_model_inst.crc_add(c, b);
    end
    c = ~c;
    get_byte(b);
    chk("crc low", c[7:0], b);
    get_byte(b);
    chk("crc high", c[15:8], b);
  endtask
  task automatic cmd(input logic [7:0] t, input logic [7:0] n, input logic [7:0] d,
    input logic [7:0] bad);
    @(posedge clk);
    #1;
    host_model_inst.send_pkt(t, n, d, bad);
  endtask
  initial begin
    seed = 6324;
    {rst_b, press, rel, pmask, rmask, sel, illegal} = '0;
    repeat (10) @(posedge clk);
    #1 rst_b = 1'b1;
    chk("txd idle", 1, txd);
    chk("fast baud", 0, fast);
    // echo at the default rate with a random payload byte
    r = $random(seed);
    cmd(8'h00, 8'h01, r[7:0], 8'h00);
    expect_pkt(8'h40, 8'h01, r);
    chk("taken count", 1, vcnt);
    // rate switch answered at the old rate, flag rises after the answer
    cmd({`CLS_CMD, `CODE_BAUD}, 8'h01, 8'h01, 8'h00);
    expect_pkt(8'h61, 8'h00, 0);
    for (int w = 0; w < 2 * DIV_S && fast !== 1'b1; w++) @(posedge clk);
    #1;
    chk("fast baud", 1, fast);
    // bad checksum dropped; the following good echo is answered alone
    cmd(8'h00, 8'h00, 8'h00, 8'h5A);
    cmd(8'h00, 8'h00, 8'h00, 8'h00);
    expect_pkt(8'h40, 8'h00, 0);
    chk("taken count", 3, vcnt);
    // illegal content: error class keeps the command code
    r = $random(seed);
    code = (r[5:0] == `CODE_BAUD || r[5:0] == `CODE_PING) ? 6'h15 : r[5:0];
    illegal = 1'b1;
    cmd({2'h0, code}, 8'h00, 8'h00, 8'h00);
    expect_pkt({`CLS_ERR, code}, 8'h00, 0);
    chk("cmd type", {2'h0, code}, ctype);
    illegal = 1'b0;
    // every key: press of k and release of j enabled, the other two masked
    for (int k = 0; k < 6; k++) begin
      j = (k + 1) % 6;
      pmask = 6'h01 << k;
      rmask = 6'h01 << j;
      press = pmask | rmask;
      @(posedge clk);
      #1 press = 6'h00;
      rel = pmask | rmask;
      @(posedge clk);
      #1 rel = 6'h00;
      expect_pkt(`TYPE_KEY, `KEY_LEN, k + 1);
      expect_pkt(`TYPE_KEY, `KEY_LEN, j + 7);
    end
    // random sensor; selection cleared once its report is on the line
    for (int t = 0; t < 2; t++) begin
      r = $random(seed);
      s = r[4:0];
      sel = 32'h1 << s;
      @(negedge txd);
      #1 sel = '0;
      expect_pkt(`TYPE_TEMP, `TEMP_LEN, {7'h0, s[0], s, 3'h2, 8'hA5, 3'h0, s});
    end
    repeat (3 * RPT) @(posedge clk);
    #1;
    chk("quiet line", 0, host_model_inst.rxq.size());
    chk("txd idle", 1, txd);
    wrap_up();
  end
endmodule
